// file: design/lse_pkg.sv
// Shared constants for the line status event logic
package lse_pkg;

   // Two line channels, eight status sources each
   localparam int NCH = 2;
   localparam int NSRC = 8;

   // Bit positions inside status, mask, edge select and event registers
   localparam int GAIN_RANGE_BIT = 7;
   localparam int LOOP_UP_BIT = 6;
   localparam int LOOP_DOWN_BIT = 5;
   localparam int PATTERN_SYNC_BIT = 4;
   localparam int TX_CLOCK_BIT = 3;
   localparam int DRIVER_FAULT_BIT = 2;
   localparam int ALARM_SIGNAL_BIT = 1;
   localparam int NO_SIGNAL_BIT = 0;

   // Register indices; byte address is four times the index
   localparam logic [5:0] CTRL_IDX = 6'h10;
   localparam logic [5:0] MASK_IDX = 6'h13;
   localparam logic [5:0] EDGE_IDX = 6'h15;
   localparam logic [5:0] LINE_STATUS_CH1_IDX = 6'h16;
   localparam logic [5:0] LINE_STATUS_CH2_IDX = 6'h36;
   localparam logic [5:0] LOOP_STATUS_IDX = 6'h17;
   localparam logic [5:0] EVENT_IDX = 6'h18;
   localparam logic [5:0] CH_STEP = LINE_STATUS_CH2_IDX - LINE_STATUS_CH1_IDX;

   // Field positions in the own control and loopback status words
   localparam int CTRL_AUTO_REMOTE_LOOP_ENABLE_BIT = 0;
   localparam int LOOP_ACTIVE_BIT = 5;

   // Reset values
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] EDGE_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] EVENT_RST = 8'h00;
   localparam logic CTRL_RST = 1'b0;

   // Timing at the 25 MHz bus clock
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned LOOP_T_SHORT_MS = 40;
   localparam int unsigned LOOP_T_LONG_MS = 5100;
   localparam int unsigned LOOP_SHORT_CYC = LOOP_T_SHORT_MS * CLK_KHZ;
   localparam int unsigned LOOP_LONG_CYC = LOOP_T_LONG_MS * CLK_KHZ;
   localparam int QUAL_W = 27;
   localparam logic [6:0] TRANSMIT_CLOCK_IN_LOSS_CYC = 7'h46;

endpackage : lse_pkg

// file: design/lse_code_qual.sv
// Qualifying timer for one inband loopback code detector
`timescale 1ns/1ps
module lse_code_qual
   import lse_pkg::*;
#(
   parameter int unsigned SHORT_CYC = LOOP_SHORT_CYC,
   parameter int unsigned LONG_CYC = LOOP_LONG_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic code_seen,
   input wire logic long_mode,
   output logic qualified
);

   typedef struct packed {
      logic [QUAL_W-1:0] cnt;
      logic hit;
   } lse_qual_t;

   lse_qual_t q;
   lse_qual_t d;

   ////////////////////////////////////////////////////////////////////////////
   // Count cycles of clean code; set once the count reaches the limit
   always_comb begin
      logic [QUAL_W-1:0] lim;
      lim = long_mode ? QUAL_W'(LONG_CYC) : QUAL_W'(SHORT_CYC);
      d = q;
      if (!code_seen) begin
         // Error rate too high or pattern gone: drop at once
         d.cnt = '0;
         d.hit = 1'b0;
      end else if (!q.hit) begin
         if (q.cnt == lim) begin
            d.hit = 1'b1;
         end else begin
            d.cnt = q.cnt + QUAL_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign qualified = q.hit;

endmodule : lse_code_qual

// file: design/lse_tx_watch.sv
// Transmit clock activity watchdog counted on the bus clock
`timescale 1ns/1ps
module lse_tx_watch
   import lse_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic transmit_clock_in,
   output logic stuck
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [6:0] cnt;
      logic stuck;
   } lse_watch_t;

   lse_watch_t q;
   lse_watch_t d;

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop sync, then count cycles since the last level change
   always_comb begin
      d = q;
      d.s1 = transmit_clock_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 != q.s3) begin
         d.cnt = '0;
      end else if (q.cnt != 7'h7F) begin
         d.cnt = q.cnt + 7'h01; // Saturates so a dead clock stays flagged
      end
      d.stuck = (d.cnt > TRANSMIT_CLOCK_IN_LOSS_CYC);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign stuck = q.stuck;

endmodule : lse_tx_watch

// file: design/lse_line_status.sv
// Line status monitor and event logic for two channels, APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module lse_line_status
   import lse_pkg::*;
#(
   parameter int unsigned LOOP_SHORT_CYC_P = LOOP_SHORT_CYC,
   parameter int unsigned LOOP_LONG_CYC_P = LOOP_LONG_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] gain_out_of_range,
   input wire logic [1:0] loop_up_code_seen,
   input wire logic [1:0] loop_down_code_seen,
   input wire logic [1:0] pattern_locked,
   input wire logic [1:0] transmit_clock_in,
   input wire logic [1:0] driver_short,
   input wire logic [1:0] alarm_signal_seen,
   input wire logic [1:0] no_signal_seen,
   output logic [1:0] irq_req,
   output logic [1:0] remote_loop_active
);

   ////////////////////////////////////////////////////////////////////////////
   // State of the whole block

   typedef struct packed {
      logic [NCH-1:0][NSRC-1:0] stat;
      logic [NCH-1:0][NSRC-1:0] prev;
      logic [NCH-1:0][NSRC-1:0] mask;
      logic [NCH-1:0][NSRC-1:0] edge_sel;
      logic [NCH-1:0][NSRC-1:0] events;
      logic [NCH-1:0] auto_remote_loop_enable;
      logic [NCH-1:0] rloop;
      logic [31:0] rdata;
   } lse_state_t;

   lse_state_t q;
   lse_state_t d;

   logic [NCH-1:0][NSRC-1:0] raw;
   logic [NCH-1:0] loop_up_status;
   logic [NCH-1:0] loop_down_status;
   logic [NCH-1:0] tx_clock_stuck_status;
   logic [5:0] idx;
   logic setup;
   logic access;

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase decode

   // Word index; the top index bit picks the channel
   assign idx = paddr[7:2];
   assign setup = psel & ~penable;
   assign access = psel & penable;

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel detectors

   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         // Loop-up code qualifier
         lse_code_qual #(
            .SHORT_CYC(LOOP_SHORT_CYC_P),
            .LONG_CYC(LOOP_LONG_CYC_P)
         ) u_up (
            .pclk(pclk),
            .presetn(presetn),
            .code_seen(loop_up_code_seen[c]),
            .long_mode(q.auto_remote_loop_enable[c]),
            .qualified(loop_up_status[c])
         );

         // Loop-down code qualifier
         lse_code_qual #(
            .SHORT_CYC(LOOP_SHORT_CYC_P),
            .LONG_CYC(LOOP_LONG_CYC_P)
         ) u_down (
            .pclk(pclk),
            .presetn(presetn),
            .code_seen(loop_down_code_seen[c]),
            .long_mode(q.auto_remote_loop_enable[c]),
            .qualified(loop_down_status[c])
         );

         // Transmit clock watchdog
         lse_tx_watch u_txw (
            .pclk(pclk),
            .presetn(presetn),
            .transmit_clock_in(transmit_clock_in[c]),
            .stuck(tx_clock_stuck_status[c])
         );

         // Live status word in register bit order
         assign raw[c][GAIN_RANGE_BIT] = gain_out_of_range[c];
         assign raw[c][LOOP_UP_BIT] = loop_up_status[c];
         assign raw[c][LOOP_DOWN_BIT] = loop_down_status[c];
         assign raw[c][PATTERN_SYNC_BIT] = pattern_locked[c];
         assign raw[c][TX_CLOCK_BIT] = tx_clock_stuck_status[c];
         assign raw[c][DRIVER_FAULT_BIT] = driver_short[c];
         assign raw[c][ALARM_SIGNAL_BIT] = alarm_signal_seen[c];
         assign raw[c][NO_SIGNAL_BIT] = no_signal_seen[c];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register map helpers

   // True for any index the slave decodes
   function automatic logic idx_hit(input logic [5:0] i);
      logic [4:0] l;
      l = i[4:0];
      return (l == CTRL_IDX[4:0]) || (l == MASK_IDX[4:0]) ||
             (l == EDGE_IDX[4:0]) || (l == LINE_STATUS_CH1_IDX[4:0]) ||
             (l == LOOP_STATUS_IDX[4:0]) || (l == EVENT_IDX[4:0]);
   endfunction : idx_hit

   // Read value of one register; unmapped reads give zero
   function automatic logic [31:0] rd_val(input lse_state_t s, input logic [5:0] i);
      logic [4:0] l;
      logic c;
      logic [31:0] v;
      l = i[4:0];
      c = i[5];
      v = '0;
      if (l == CTRL_IDX[4:0]) begin
         v[CTRL_AUTO_REMOTE_LOOP_ENABLE_BIT] = s.auto_remote_loop_enable[c];
      end else if (l == MASK_IDX[4:0]) begin
         v[7:0] = s.mask[c];
      end else if (l == EDGE_IDX[4:0]) begin
         v[7:0] = s.edge_sel[c];
      end else if (l == LINE_STATUS_CH1_IDX[4:0]) begin
         v[7:0] = s.stat[c];
      end else if (l == LOOP_STATUS_IDX[4:0]) begin
         v[LOOP_ACTIVE_BIT] = s.rloop[c];
      end else if (l == EVENT_IDX[4:0]) begin
         v[7:0] = s.events[c];
      end
      return v;
   endfunction : rd_val

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [NSRC-1:0] rise;
      logic [NSRC-1:0] fall;
      logic [NSRC-1:0] ev;
      logic [NSRC-1:0] clr;
      logic wr;
      logic rd_done;
      rise = '0;
      fall = '0;
      ev = '0;
      clr = '0;
      wr = access & pwrite & idx_hit(idx);
      rd_done = access & ~pwrite & (idx[4:0] == EVENT_IDX[4:0]);
      d = q;

      for (int c = 0; c < NCH; c++) begin
         // Status sampled each cycle, previous copy kept for edges
         d.stat[c] = raw[c];
         d.prev[c] = q.stat[c];
         rise = q.stat[c] & ~q.prev[c];
         fall = ~q.stat[c] & q.prev[c];

         // Unmasked rising always counts, falling only with both-edge select
         ev = (rise | (q.edge_sel[c] & fall)) & ~q.mask[c];

         // Only bits the host actually saw are cleared, so an event
         // landing between setup and access is kept for the next read
         clr = '0;
         if (rd_done && (idx[5] == c[0])) begin
            clr = q.rdata[7:0];
         end
         d.events[c] = (q.events[c] & ~clr) | ev;

         // Remote loopback follows qualified code edges;
         // down wins when both rise together, the safe state
         if (rise[LOOP_UP_BIT]) begin
            d.rloop[c] = 1'b1;
         end
         if (rise[LOOP_DOWN_BIT]) begin
            d.rloop[c] = 1'b0;
         end

         // Host writes, taken at the access edge
         if (wr && (idx[5] == c[0])) begin
            if (idx[4:0] == MASK_IDX[4:0]) begin
               d.mask[c] = pwdata[7:0];
            end else if (idx[4:0] == EDGE_IDX[4:0]) begin
               d.edge_sel[c] = pwdata[7:0];
            end else if (idx[4:0] == CTRL_IDX[4:0]) begin
               d.auto_remote_loop_enable[c] = pwdata[CTRL_AUTO_REMOTE_LOOP_ENABLE_BIT];
            end
         end
      end

      // Read data latched in setup, so prdata is a flop in access
      if (setup) begin
         d.rdata = rd_val(q, idx);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.stat <= {NCH{STATUS_RST}};
         q.prev <= {NCH{STATUS_RST}};
         q.mask <= {NCH{MASK_RST}};
         q.edge_sel <= {NCH{EDGE_RST}};
         q.events <= {NCH{EVENT_RST}};
         q.auto_remote_loop_enable <= {NCH{CTRL_RST}};
         q.rloop <= '0;
         q.rdata <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Zero wait states; an unmapped word answers with an error
   assign pready = 1'b1;
   assign pslverr = access & ~idx_hit(idx);
   assign prdata = q.rdata;

   // Request stays up until every latched event is read away
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_irq
         assign irq_req[c] = |q.events[c];
      end
   endgenerate

   assign remote_loop_active = q.rloop;

endmodule : lse_line_status

// file: dv/lse_host_model.sv
// Host processor model: APB master that reads and writes the block's registers
`timescale 1ns/1ps
module lse_host_model (
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   // Bus idles low from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // One transfer; request held until pready is seen high, the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : lse_host_model

// file: dv/lse_line_status_properties.sv
// Checker for bus answers, masking and remote loopback of the status block
`timescale 1ns/1ps
module lse_line_status_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] loop_up_code_seen,
   input wire logic [1:0] loop_down_code_seen,
   input wire logic [1:0] irq_req,
   input wire logic [1:0] remote_loop_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Address decode, channel bit ignored
   wire mapped = paddr[6:2] inside {5'h10, 5'h13, 5'h15, 5'h16, 5'h17, 5'h18};
   wire rd_acc = psel && penable && !pwrite;
   logic mask_wr_q;
   // Remembers any mask write; until then all sources stay masked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mask_wr_q <= 1'b0;
      else if (psel && penable && pwrite && paddr[6:2] == 5'h13) mask_wr_q <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_ready; 1'b1 |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err_unmapped; psel && penable && !mapped |-> pslverr; endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
   property p_err_only; pslverr |-> psel && penable && mapped == 1'b0; endproperty
   a_err_only: assert property (p_err_only) else $error("stray error");
   property p_upper; rd_acc |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_unmapped_zero; rd_acc && !mapped |-> prdata == 32'h0; endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_masked; !mask_wr_q |-> irq_req == 2'b00; endproperty
   a_masked: assert property (p_masked) else $error("request while masked");
   property p_loop_on; $rose(remote_loop_active[0]) |-> $past(loop_up_code_seen[0], 3); endproperty
   a_loop_on: assert property (p_loop_on) else $error("loopback on without code");
   property p_loop_off;
      $fell(remote_loop_active[0]) |-> $past(loop_down_code_seen[0], 3);
   endproperty
   a_loop_off: assert property (p_loop_off) else $error("loopback off without code");
   c_err: cover property (psel && penable && pslverr);
   c_loop: cover property ($rose(remote_loop_active[0]));
   c_irq: cover property ($rose(irq_req[1]));
endmodule : lse_line_status_checker

bind lse_line_status lse_line_status_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .loop_up_code_seen, .loop_down_code_seen, .irq_req,
   .remote_loop_active);

// file: dv/lse_line_status_tb.sv
// Self-checking bench for the line status event block
`timescale 1ns/1ps
module lse_line_status_tb;
   import lse_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] gain, up, dn, lock, txc, drv, ais, los, irq, rloop, tx_run;
   int mismatches, cmp_count, cyc, ch, b;
   int ev[2], st[2], mk[2], es[2];
   int bits[5] = '{7, 4, 2, 1, 0};

   always #20 pclk = ~pclk;
   // Short qualifying counts keep the run brief
   lse_line_status #(.LOOP_SHORT_CYC_P(20), .LOOP_LONG_CYC_P(50)) uut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gain_out_of_range(gain),
      .loop_up_code_seen(up), .loop_down_code_seen(dn), .pattern_locked(lock),
      .transmit_clock_in(txc), .driver_short(drv), .alarm_signal_seen(ais),
      .no_signal_seen(los), .irq_req(irq), .remote_loop_active(rloop));
   lse_host_model host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
      .pwdata);

   // Transmit clocks toggle every other cycle while running; hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      txc <= txc ^ (tx_run & {2{cyc[0]}});
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         mismatches++;
      end
   endtask : chk
   task complete_run;
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   function automatic logic [7:0] ad(logic [5:0] i, int c);
      return {i + 6'(c) * CH_STEP, 2'b00};
   endfunction : ad
   task wr(logic [5:0] i, int c, logic [7:0] d);
      host.xfer(1'b1, ad(i, c), {24'h0, d}, rd, er);
   endtask : wr
   task rdc(string n, logic [5:0] i, int c, logic [31:0] e);
      host.xfer(1'b0, ad(i, c), 32'h0, rd, er);
      chk(n, e, rd);
   endtask : rdc
   // Drives one status input and predicts the latched event
   task setb(int c, int k, logic v);
      case (k)
         7: gain[c] <= v;
         4: lock[c] <= v;
         2: drv[c] <= v;
         1: ais[c] <= v;
         default: los[c] <= v;
      endcase
      if (st[c][k] != v && !mk[c][k] && (v || es[c][k])) ev[c] |= 1 << k;
      st[c][k] = v;
   endtask : setb
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {gain, up, dn, lock, drv, ais, los, txc} = '0;
      tx_run = 2'b11;
      cyc = 0;
      mk = '{255, 255};
      void'($urandom(63));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (ch = 0; ch < 2; ch++) begin
         rdc("mask", MASK_IDX, ch, MASK_RST);
         rdc("edge", EDGE_IDX, ch, EDGE_RST);
         wr(LINE_STATUS_CH1_IDX, ch, 8'hFF);
         rdc("status", LINE_STATUS_CH1_IDX, ch, STATUS_RST);
         host.xfer(1'b0, ad(6'h01, ch), 32'h0, rd, er);
         chk("unmapped err", 1, er);
      end
      $display("reset and access test done");
      repeat (40) begin
         ch = $urandom_range(1, 0);
         mk[ch] = $urandom_range(255, 0);
         es[ch] = $urandom_range(255, 0);
         wr(MASK_IDX, ch, mk[ch][7:0]);
         wr(EDGE_IDX, ch, es[ch][7:0]);
         b = bits[$urandom_range(4, 0)];
         setb(ch, b, !st[ch][b]);
         repeat (3) @(posedge pclk);
         chk("irq", ev[ch] != 0, irq[ch]);
         rdc("status", LINE_STATUS_CH1_IDX, ch, st[ch]);
         rdc("event", EVENT_IDX, ch, ev[ch]);
         ev[ch] = 0;
         @(posedge pclk);
         chk("irq cleared", 0, irq[ch]);
      end
      $display("event test done");
      wr(MASK_IDX, 0, 8'h00);
      wr(CTRL_IDX, 0, 8'h00);
      up[0] <= 1'b1;
      repeat (30) @(posedge pclk);
      chk("loop on", 1, rloop[0]);
      rdc("loop up", LINE_STATUS_CH1_IDX, 0, st[0] | 32'h40);
      up[0] <= 1'b0;
      dn[0] <= 1'b1;
      repeat (30) @(posedge pclk);
      chk("loop off", 0, rloop[0]);
      rdc("loop down", LINE_STATUS_CH1_IDX, 0, st[0] | 32'h20);
      rdc("loop events", EVENT_IDX, 0, 32'h60);
      dn[0] <= 1'b0;
      wr(CTRL_IDX, 0, 8'h01);
      up[0] <= 1'b1;
      repeat (30) @(posedge pclk);
      rdc("long wait", LINE_STATUS_CH1_IDX, 0, st[0]);
      repeat (30) @(posedge pclk);
      rdc("long done", LINE_STATUS_CH1_IDX, 0, st[0] | 32'h40);
      up[0] <= 1'b0;
      $display("loopback test done");
      wr(MASK_IDX, 1, 8'hF7);
      wr(EDGE_IDX, 1, 8'h08);
      tx_run[1] <= 1'b0;
      repeat (60) @(posedge pclk);
      rdc("tx early", LINE_STATUS_CH1_IDX, 1, st[1]);
      repeat (20) @(posedge pclk);
      rdc("tx stuck", LINE_STATUS_CH1_IDX, 1, st[1] | 32'h08);
      rdc("tx event", EVENT_IDX, 1, 32'h08);
      tx_run[1] <= 1'b1;
      repeat (20) @(posedge pclk);
      rdc("tx back", EVENT_IDX, 1, 32'h08);
      chk("loop ch2 idle", 0, rloop[1]);
      $display("clock loss test done");
      complete_run();
   end
endmodule : lse_line_status_tb
